// ---- src/aic_pkg.sv ----
// constants, field layouts and carrier types for the input configuration and channel select block
// assumes a single 10 MHz clock domain and an axi4-lite master on the register side
package aic_pkg;

    // register byte addresses
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_STATUS  = 4'h4;

    // control register field positions
    localparam int CTRL_ADDR_LSB    = 0;  // channel_address_field, 3 bits
    localparam int CTRL_CFG0_BIT    = 3;  // input_config_bit0
    localparam int CTRL_CFG1_BIT    = 4;  // input_config_bit1
    localparam int CTRL_SHADOW_BIT  = 5;  // channel_list_select_bit
    localparam int CTRL_CYCLE_BIT   = 6;  // auto_cycle_bit
    localparam int CTRL_WIDTH       = 7;
    localparam logic [6:0] CTRL_RESET = 7'h00;

    // status register field positions
    localparam int STAT_POS_LSB     = 0;  // positive mux input, 3 bits
    localparam int STAT_NEG_LSB     = 3;  // negative mux input, 3 bits
    localparam int STAT_NEGGND_BIT  = 6;  // negative sample input tied to ground
    localparam int STAT_MODE_LSB    = 7;  // input config, 2 bits
    localparam int STAT_DIFF_BIT    = 9;  // fully differential conversion
    localparam int STAT_TRAD_BIT    = 10; // traditional multichannel active
    localparam int STAT_VALID_BIT   = 11; // selection fits the mode

    // converter resolutions
    localparam int RES_FULL = 12;  // 4096 codes
    localparam int RES_LOW  = 10;  // 1024 codes

    // axi response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // input grouping, codes are {bit1, bit0}
    typedef enum logic [1:0] {
        MODE_SINGLE  = 2'h0,
        MODE_PSEUDO4 = 2'h1,
        MODE_DIFF4   = 2'h2,
        MODE_PSEUDO7 = 2'h3
    } aic_mode_type;

    // multiplexer steering word
    typedef struct packed {
        logic       valid;
        logic       trad;
        logic       diff;
        logic [1:0] mode;
        logic       neg_gnd;
        logic [2:0] neg_sel;
        logic [2:0] pos_sel;
    } aic_mux_type;

endpackage

// ---- src/aic_span.sv ----
// maps a signed differential sample onto an unsigned output code
// assumes the sample is already resolved to the chosen resolution
`timescale 1ns/1ps
module aic_span #(
    parameter int RES = 12
) (
    // clock and reset
    input  wire logic           clk,
    input  wire logic           rst,
    // sample in, two's complement of the difference
    input  wire logic [RES-1:0] diff_sample,
    input  wire logic           diff_mode,
    // code out
    output logic      [RES-1:0] code
);

    // offset by half scale so negative full span lands on zero code
    always_ff @(posedge clk) begin
        if (rst) begin
            code <= '0;
        end else if (diff_mode) begin
            code <= {~diff_sample[RES-1], diff_sample[RES-2:0]};
        end else begin
            code <= diff_sample;
        end
    end

endmodule

// ---- src/aic_top.sv ----
// input configuration and channel select with an axi4-lite register slave
// assumes one clock REF_CLK at 10 MHz, synchronous active high reset, host drives only valid axi traffic
`timescale 1ns/1ps
module aic_top #(
    parameter int RES = aic_pkg::RES_FULL
) (
    // clock and reset
    input  wire logic           REF_CLK,
    input  wire logic           RST,
    // axi4-lite write address and data
    input  wire logic [3:0]     S_AXI_AWADDR,
    input  wire logic           S_AXI_AWVALID,
    output logic                S_AXI_AWREADY,
    input  wire logic [31:0]    S_AXI_WDATA,
    input  wire logic [3:0]     S_AXI_WSTRB,
    input  wire logic           S_AXI_WVALID,
    output logic                S_AXI_WREADY,
    // axi4-lite write response
    output logic [1:0]          S_AXI_BRESP,
    output logic                S_AXI_BVALID,
    input  wire logic           S_AXI_BREADY,
    // axi4-lite read
    input  wire logic [3:0]     S_AXI_ARADDR,
    input  wire logic           S_AXI_ARVALID,
    output logic                S_AXI_ARREADY,
    output logic [31:0]         S_AXI_RDATA,
    output logic [1:0]          S_AXI_RRESP,
    output logic                S_AXI_RVALID,
    input  wire logic           S_AXI_RREADY,
    // conversion side
    input  wire logic           CONV_START,
    input  wire logic [RES-1:0] DIFF_SAMPLE,
    output logic [RES-1:0]      CODE,
    output logic [2:0]          MUX_POS,
    output logic [2:0]          MUX_NEG,
    output logic                NEG_TO_GROUND,
    output logic                DIFF_ACTIVE
);

    logic [aic_pkg::CTRL_WIDTH-1:0] control;
    logic                          aw_held;
    logic                          w_held;
    logic [3:0]                    aw_addr;
    logic [31:0]                   w_data;
    logic                          w_lane0;
    aic_pkg::aic_mux_type          next_mux;
    aic_pkg::aic_mux_type          mux;
    logic                          conv_start_meta;
    logic                          conv_start_sync;
    logic                          conv_start_last;
    logic [2:0]                    addr_field;
    aic_pkg::aic_mode_type         mode;
    logic                          trad;

    // write channel capture, address and data taken in either order
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            aw_held <= 1'b0;
            aw_addr <= 4'h0;
        end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_held <= 1'b1;
            aw_addr <= S_AXI_AWADDR;
        end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            w_held  <= 1'b0;
            w_data  <= 32'h0000_0000;
            w_lane0 <= 1'b0;
        end else if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_held  <= 1'b1;
            w_data  <= S_AXI_WDATA;
            w_lane0 <= S_AXI_WSTRB[0];
        end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            w_held <= 1'b0;
        end
    end

    // ready only while nothing of that channel is held and no response pending
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
        end else begin
            S_AXI_AWREADY <= !aw_held && !(S_AXI_AWVALID && S_AXI_AWREADY) && !S_AXI_BVALID;
            S_AXI_WREADY  <= !w_held && !(S_AXI_WVALID && S_AXI_WREADY) && !S_AXI_BVALID;
        end
    end

    // control register write and write response
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            control      <= aic_pkg::CTRL_RESET;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= aic_pkg::RESP_OKAY;
        end else if (S_AXI_BVALID) begin
            if (S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end else if (aw_held && w_held) begin
            S_AXI_BVALID <= 1'b1;
            if (aw_addr == aic_pkg::ADDR_CONTROL) begin
                // each write with strobe lane 0 set and the shadow and cycle bits clear replaces the address for the next conversion
                if (w_lane0) begin
                    control <= w_data[aic_pkg::CTRL_WIDTH-1:0];
                end
                S_AXI_BRESP <= aic_pkg::RESP_OKAY;
            end else if (aw_addr == aic_pkg::ADDR_STATUS) begin
                S_AXI_BRESP <= aic_pkg::RESP_OKAY; // read-only, write ignored
            end else begin
                S_AXI_BRESP <= aic_pkg::RESP_SLVERR;
            end
        end
    end

    // read channel, one cycle to answer
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0000_0000;
            S_AXI_RRESP   <= aic_pkg::RESP_OKAY;
        end else if (S_AXI_RVALID) begin
            S_AXI_ARREADY <= 1'b0;
            if (S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b1;
            if (S_AXI_ARADDR == aic_pkg::ADDR_CONTROL) begin
                S_AXI_RDATA <= {25'h0000000, control};
                S_AXI_RRESP <= aic_pkg::RESP_OKAY;
            end else if (S_AXI_ARADDR == aic_pkg::ADDR_STATUS) begin
                S_AXI_RDATA <= {20'h00000, mux};
                S_AXI_RRESP <= aic_pkg::RESP_OKAY;
            end else begin
                S_AXI_RDATA <= 32'h0000_0000;
                S_AXI_RRESP <= aic_pkg::RESP_SLVERR;
            end
        end else begin
            S_AXI_ARREADY <= 1'b1;
        end
    end

    // conversion start comes from a pin, two flops before use
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            conv_start_meta <= 1'b0;
            conv_start_sync <= 1'b0;
            conv_start_last <= 1'b0;
        end else begin
            conv_start_meta <= CONV_START;
            conv_start_sync <= conv_start_meta;
            conv_start_last <= conv_start_sync;
        end
    end

    assign addr_field = control[aic_pkg::CTRL_ADDR_LSB +: 3];
    assign mode       = aic_pkg::aic_mode_type'({control[aic_pkg::CTRL_CFG1_BIT], control[aic_pkg::CTRL_CFG0_BIT]});
    // sequencer modes are outside this block; only both bits clear selects here
    assign trad       = !control[aic_pkg::CTRL_CYCLE_BIT] && !control[aic_pkg::CTRL_SHADOW_BIT];

    // decode address field against the grouping
    always_comb begin
        next_mux         = '0;
        next_mux.mode    = mode;
        next_mux.trad    = trad;
        next_mux.valid   = 1'b1;
        case (mode)
            aic_pkg::MODE_SINGLE: begin
                next_mux.pos_sel = addr_field;
                next_mux.neg_gnd = 1'b1;
            end
            aic_pkg::MODE_DIFF4: begin
                // pair index in the low two bits, the top bit is ignored
                next_mux.pos_sel = {addr_field[1:0], 1'b0};
                next_mux.neg_sel = {addr_field[1:0], 1'b1};
                next_mux.diff    = 1'b1;
            end
            aic_pkg::MODE_PSEUDO4: begin
                next_mux.pos_sel = {addr_field[1:0], 1'b0};
                next_mux.neg_sel = {addr_field[1:0], 1'b1};
            end
            aic_pkg::MODE_PSEUDO7: begin
                next_mux.pos_sel = addr_field;
                next_mux.neg_sel = 3'h7;
                next_mux.valid   = (addr_field != 3'h7);
            end
            default: begin
                next_mux.valid = 1'b0;
            end
        endcase
    end

    // steering is updated every cycle while trad is set, held while it is clear and frozen on a start edge
    // reset value matches the decode of the reset control word, so the pins show no glitch
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            mux <= '{valid: 1'b1, trad: 1'b1, diff: 1'b0, mode: 2'h0, neg_gnd: 1'b1, neg_sel: 3'h0, pos_sel: 3'h0};
        end else begin
            // the trad flag follows the sequencing bits even while the selection holds
            mux.trad <= trad;
            if (!(conv_start_sync && !conv_start_last) && trad) begin
                mux <= next_mux;
            end
        end
    end

    // pin outputs
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            MUX_POS       <= 3'h0;
            MUX_NEG       <= 3'h0;
            NEG_TO_GROUND <= 1'b1;
            DIFF_ACTIVE   <= 1'b0;
        end else begin
            MUX_POS       <= mux.pos_sel;
            MUX_NEG       <= mux.neg_sel;
            NEG_TO_GROUND <= mux.neg_gnd;
            DIFF_ACTIVE   <= mux.diff;
        end
    end

    aic_span #(
        .RES(RES)
    ) u_span (
        .clk         (REF_CLK),
        .rst         (RST),
        .diff_sample (DIFF_SAMPLE),
        .diff_mode   (mux.diff),
        .code        (CODE)
    );

endmodule

// ---- tb/aic_chk.sv ----
// checker for grouping, mux steering and code mapping
// assumes aic_top ports and one clock domain
`timescale 1ns/1ps
module aic_chk #(
    parameter int RES = 12
) (
    // clock and reset
    input wire logic           REF_CLK,
    input wire logic           RST,
    // register read and write answer
    input wire logic [3:0]     S_AXI_ARADDR,
    input wire logic           S_AXI_ARVALID,
    input wire logic           S_AXI_ARREADY,
    input wire logic [31:0]    S_AXI_RDATA,
    input wire logic [1:0]     S_AXI_RRESP,
    input wire logic           S_AXI_RVALID,
    input wire logic           S_AXI_BVALID,
    // conversion side
    input wire logic [RES-1:0] DIFF_SAMPLE,
    input wire logic [RES-1:0] CODE,
    input wire logic [2:0]     MUX_POS,
    input wire logic [2:0]     MUX_NEG,
    input wire logic           NEG_TO_GROUND,
    input wire logic           DIFF_ACTIVE
);
    logic st;
    wire logic sr = S_AXI_RVALID && st && S_AXI_RRESP == aic_pkg::RESP_OKAY;
    wire logic [1:0] md = S_AXI_RDATA[8:7];
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    // remember whether the pending read targets status
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            st <= 1'b0;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            st <= (S_AXI_ARADDR == aic_pkg::ADDR_STATUS);
        end
    end
    AST_SE: assert property (sr && md == 2'h0 |-> S_AXI_RDATA[6] && !S_AXI_RDATA[9])
        else $error("single ended not grounded");
    AST_DIFF_GND: assert property (DIFF_ACTIVE |-> !NEG_TO_GROUND)
        else $error("differential with grounded negative");
    AST_DIFF_PAIR: assert property (DIFF_ACTIVE |-> !MUX_POS[0] && MUX_NEG == MUX_POS + 3'h1)
        else $error("differential pair wrong");
    AST_PS4: assert property (sr && md == 2'h1 |-> !S_AXI_RDATA[0] && !S_AXI_RDATA[6]
        && S_AXI_RDATA[5:3] == S_AXI_RDATA[2:0] + 3'h1) else $error("pseudo pair wrong");
    AST_PS7: assert property (sr && md == 2'h3 |-> S_AXI_RDATA[5:3] == 3'h7 && !S_AXI_RDATA[6])
        else $error("common reference not used");
    AST_CODE: assert property (DIFF_ACTIVE && $past(DIFF_ACTIVE) |->
        CODE == {~$past(DIFF_SAMPLE[RES-1]), $past(DIFF_SAMPLE[RES-2:0])}) else $error("code span");
    AST_HOLD: assert property ($changed(MUX_POS) |-> $past(S_AXI_BVALID, 2) || $past(S_AXI_BVALID, 3))
        else $error("mux moved without write");
    AST_NEG: assert property (!NEG_TO_GROUND && !DIFF_ACTIVE |-> MUX_NEG == 3'h7
        || (!MUX_POS[0] && MUX_NEG == MUX_POS + 3'h1)) else $error("pseudo negative wrong");
endmodule
bind aic_top aic_chk #(.RES(RES)) u_chk (.REF_CLK, .RST, .S_AXI_ARADDR, .S_AXI_ARVALID,
    .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_BVALID, .DIFF_SAMPLE,
    .CODE, .MUX_POS, .MUX_NEG, .NEG_TO_GROUND, .DIFF_ACTIVE);

// ---- tb/aic_host.sv ----
// host model programming the control register over axi4-lite
// assumes clk shared with the slave; tasks entered just after an edge
`timescale 1ns/1ps
module aic_host (
    // clock
    input wire logic        clk,
    // write side
    output logic [3:0]      awaddr,
    output logic            awvalid,
    input wire logic        awready,
    output logic [31:0]     wdata,
    output logic [3:0]      wstrb,
    output logic            wvalid,
    input wire logic        wready,
    input wire logic [1:0]  bresp,
    input wire logic        bvalid,
    output logic            bready,
    // read side
    output logic [3:0]      araddr,
    output logic            arvalid,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp,
    input wire logic        rvalid,
    output logic            rready
);
    // idle bus from time zero
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    // each write carries the channel address, released lines show inverted data
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        {awaddr, wdata, wstrb} <= {a, d, s};
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        {awaddr, wdata, bready} <= {~a, ~d, 1'b0};
    endtask
    // read one word, rready held until the answer
    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        {araddr, arvalid, rready} <= {a, 2'h3};
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        {d, r} = {rdata, rresp};
        {araddr, rready} <= {~a, 1'b0};
    endtask
endmodule

// ---- tb/aic_bench.sv ----
// bench: every grouping and address, code span, sequencing bits, bus errors
// assumes aic_top at RES 12 driven through the aic_host model
`timescale 1ns/1ps
module aic_bench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [11:0] smp = 12'h000;
    logic [11:0] code;
    logic [3:0]  awa, ara, ws;
    logic [31:0] wd, rdat, d, e, m;
    logic [1:0]  br, rr, r;
    logic        awv, awr, wv, wrd, bv, bry, arv, arr, rv, rry;
    logic [2:0]  mp, mn;
    logic        gnd, dif;
    logic        cs = 1'b0;
    int          fails = 0;
    int          tests_run = 0;
    int          cyc = 0;
    aic_top uut (.REF_CLK(clk), .RST(rst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wrd), .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
        .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
        .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .CONV_START(cs),
        .DIFF_SAMPLE(smp), .CODE(code), .MUX_POS(mp), .MUX_NEG(mn), .NEG_TO_GROUND(gnd),
        .DIFF_ACTIVE(dif));
    aic_host u_host (.clk(clk), .awaddr(awa), .awvalid(awv), .awready(awr), .wdata(wd),
        .wstrb(ws), .wvalid(wv), .wready(wrd), .bresp(br), .bvalid(bv), .bready(bry),
        .araddr(ara), .arvalid(arv), .arready(arr), .rdata(rdat), .rresp(rr), .rvalid(rv),
        .rready(rry));
    always #50 clk = ~clk;
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            wrap_up;
        end
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        tests_run++;
        if (g !== x) begin
            fails++;
            $display("[ERR] %0t got %h want %h", $time, g, x);
        end
    endtask
    // a spare edge keeps the host from reassigning a strobe in one step
    task automatic w(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s);
        @(posedge clk);
        u_host.wr(a, v, s, r);
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        u_host.rd(a, d, r);
    endtask
    // expected status and mask of defined bits; single leaves neg open, address 7 of seven is invalid
    function automatic logic [31:0] stat(input logic [1:0] md, input logic [2:0] a);
        logic [2:0] p;
        logic [2:0] n;
        p = (md == 2'h1 || md == 2'h2) ? {a[1:0], 1'b0} : a;
        n = (md == 2'h3) ? 3'h7 : p + 3'h1;
        m = (md == 2'h0) ? 32'hFC7 : (md == 2'h3 && a == 3'h7) ? 32'hFF8 : 32'hFFF;
        return {20'h0, md != 2'h3 || a != 3'h7, 1'b1, md == 2'h2, md, md == 2'h0, n, p};
    endfunction
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk({24'h0, gnd, dif, mn, mp}, 32'h80);
        for (int md = 0; md < 4; md++) begin
            for (int a = 0; a < 8; a++) begin
                w(aic_pkg::ADDR_CONTROL, {27'h0, md[1:0], a[2:0]}, 4'hF);
                rd(aic_pkg::ADDR_STATUS);
                e = stat(md[1:0], a[2:0]);
                chk(d & m, e & m);
                @(negedge clk);
                chk({22'h0, dif, 2'h0, gnd, mn, mp} & m & 32'h27F, e & m & 32'h27F);
            end
        end
        for (int md = 0; md < 4; md += 2) begin
            w(aic_pkg::ADDR_CONTROL, {27'h0, md[1:0], 3'h1}, 4'hF);
            for (int k = 0; k < 3; k++) begin
                @(posedge clk);
                smp <= 12'h7FF + k[11:0];
                repeat (2) @(posedge clk);
                @(negedge clk);
                chk({20'h0, code}, {20'h0, md == 2 ? smp ^ 12'h800 : smp});
            end
        end
        w(aic_pkg::ADDR_CONTROL, 32'h3, 4'hF);
        for (int k = 5; k < 7; k++) begin
            w(aic_pkg::ADDR_CONTROL, (32'h1 << k) | 32'h5, 4'hF);
            rd(aic_pkg::ADDR_STATUS);
            chk({31'h0, d[10]}, 32'h0);
            @(negedge clk);
            chk({29'h0, mp}, 32'h3);
        end
        w(aic_pkg::ADDR_CONTROL, 32'h6, 4'hF);
        w(aic_pkg::ADDR_CONTROL, 32'h11, 4'h0);
        rd(aic_pkg::ADDR_CONTROL);
        chk(d, 32'h6);
        @(negedge clk);
        chk({29'h0, mp}, 32'h6);
        // a start edge arriving as the write lands may only delay the new selection
        @(posedge clk);
        cs <= 1'b1;
        u_host.wr(aic_pkg::ADDR_CONTROL, 32'h12, 4'hF, r);
        cs <= 1'b0;
        rd(aic_pkg::ADDR_STATUS);
        chk(d, stat(2'h2, 3'h2));
        @(negedge clk);
        chk({29'h0, mp}, 32'h4);
        w(4'h8, 32'h1, 4'hF);
        chk({30'h0, r}, {30'h0, aic_pkg::RESP_SLVERR});
        rd(4'hC);
        chk({30'h0, r}, {30'h0, aic_pkg::RESP_SLVERR});
        wrap_up;
    end
endmodule
